//--- include/sfsp_pkg.sv
// package for the serial flash spi port: opcodes, geometry, status layout, timing
package sfsp_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int PAGE_COUNT = 32768;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_PAGES = 16;
  localparam int BLK32_PAGES = 128;
  localparam int BLK64_PAGES = 256;
  localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_FREAD  = 8'h0b;
  localparam logic [7:0] OP_DREAD  = 8'h3b;
  localparam logic [7:0] OP_PROG   = 8'h02;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hd8;
  localparam logic [7:0] OP_CE     = 8'hc7;

  // ------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] ST_WR_MASK = 8'hbc;
  localparam logic [7:0] ST_RESET   = 8'h00;

  // ------------------------------------------------------------
  // counts and timing
  // ------------------------------------------------------------
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam int T_BUSY_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    SFSP_IDLE  = 3'b000,
    SFSP_OPC   = 3'b001,
    SFSP_ADDR  = 3'b010,
    SFSP_DUMMY = 3'b011,
    SFSP_DATA  = 3'b100,
    SFSP_DONE  = 3'b101
  } sfsp_state_t;

  // serial pins sampled from the host side
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic hold_n;
    logic wguard_n;
    logic serial_inout;
  } sfsp_pins_t;

endpackage : sfsp_pkg

//--- tb/sfsp_host.sv
// host side spi master model driving the serial pins
module sfsp_host #(
  parameter int HALF = 2
) (
  // clock
  input  wire logic            i_clock,
  // device outputs
  input  wire logic            i_dout,
  input  wire logic            i_inout_out,
  input  wire logic            i_inout_oe,
  // pins to the device
  output sfsp_pkg::sfsp_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk = 1'b0;
  logic sel_n = 1'b1;
  logic hold_n = 1'b1;
  logic wg_n = 1'b1;
  logic si = 1'b0;
  logic drv = 1'b1;
  logic mode3 = 1'b0;
  // released inout shows the device level or the inverse of the last bit
  assign o_pins = '{sclk, sel_n, hold_n, wg_n, drv ? si : (i_inout_oe ? i_inout_out : ~si)};
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  task automatic hw();
    repeat (HALF) @(posedge i_clock);
    #1;
  endtask : hw
  task automatic start();
    sclk = mode3;
    hw();
    sel_n = 1'b0;
    hw();
  endtask : start
  task automatic stop();
    sclk = mode3;
    hw();
    sel_n = 1'b1;
    drv = 1'b1;
    hw();
  endtask : stop
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      si = tx[i];
      hw();
      rx[i] = i_dout;
      sclk = 1'b1;
      hw();
    end
  endtask : xb
  task automatic xd(output logic [7:0] rx);
    drv = 1'b0;
    for (int i = 7; i > 0; i -= 2)
    begin
      sclk = 1'b0;
      hw();
      rx[i] = o_pins.serial_inout;
      rx[i-1] = i_dout;
      sclk = 1'b1;
      hw();
    end
  endtask : xd
  task automatic pause(input logic on);
    sclk = 1'b0;
    hw();
    hold_n = ~on;
    hw();
  endtask : pause
endmodule : sfsp_host

//--- tb/sfsp_port_assertions.sv
// checker for the serial flash spi port, bound to its ports
module sfsp_port_assertions (
  // clock and reset
  input wire logic                 i_clock,
  input wire logic                 i_rstn,
  input wire logic                 i_ce,
  // pins and outputs
  input wire sfsp_pkg::sfsp_pins_t i_pins,
  input wire logic                 o_dout,
  input wire logic                 o_dout_oe,
  input wire logic                 o_inout_out,
  input wire logic                 o_inout_oe,
  input wire logic                 o_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic armed_r;
  logic held;
  assign held = !i_pins.sel_n && !i_pins.hold_n && !i_pins.sclk;
  always_ff @(posedge i_clock) armed_r <= i_rstn & (armed_r | i_pins.sel_n);
  // shadow of the first byte shifted in after select
  logic       sclk_q;
  logic [3:0] n_op;
  logic [7:0] op_seen;
  always_ff @(posedge i_clock)
  begin
    sclk_q <= i_pins.sclk;
    if (!i_rstn || i_pins.sel_n)
      n_op <= 4'h0;
    else if (i_pins.sclk && !sclk_q && i_pins.hold_n && n_op != 4'h8)
    begin
      op_seen <= {op_seen[6:0], i_pins.serial_inout};
      n_op <= n_op + 4'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_DESEL_QUIET: assert property (i_pins.sel_n && $past(i_pins.sel_n) |->
    !o_dout_oe && !o_inout_oe) else $error("output driven while deselected");
  AST_ARMED: assert property (o_dout_oe |-> armed_r)
    else $error("output driven before first select edge");
  AST_FALL_SHIFT: assert property (o_dout_oe && $past(o_dout_oe) && $changed(o_dout)
    |-> !$past(i_pins.sclk)) else $error("data changed outside falling clock");
  AST_HOLD_FLOAT: assert property (held && $past(held) |=>
    !o_dout_oe && !o_inout_oe) else $error("output driven while paused");
  AST_HOLD_FREEZE: assert property (held && $past(held) |=> $stable(o_dout))
    else $error("data moved while paused");
  AST_DUAL_ONLY: assert property (o_inout_oe |-> o_dout_oe && n_op == 4'h8
    && op_seen == sfsp_pkg::OP_DREAD)
    else $error("inout driven outside dual read");
  AST_BUSY_SPAN: assert property ($rose(o_busy) |=> o_busy[*8] ##[1:150] !o_busy)
    else $error("busy span wrong");
  AST_BUSY_DESEL: assert property ($rose(o_busy) |-> i_pins.sel_n)
    else $error("busy began while selected");
endmodule : sfsp_port_assertions

bind sfsp_port sfsp_port_assertions u_chk (.i_clock, .i_rstn, .i_ce, .i_pins, .o_dout,
  .o_dout_oe, .o_inout_out, .o_inout_oe, .o_busy);

//--- tb/sfsp_port_tb.sv
// self-checking bench for the serial flash spi port
module sfsp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 i_clock = 1'b0;
  logic                 i_rstn = 1'b0;
  sfsp_pkg::sfsp_pins_t pins;
  logic                 dout, dout_oe, io_out, io_oe, busy;
  logic [7:0]           s, r1, r2, r3, j;
  int                   n_errors = 0;
  int                   n_compared = 0;
  initial forever #5 i_clock = ~i_clock;
  sfsp_port dut (.i_clock, .i_rstn, .i_ce(1'b1), .i_pins(pins), .o_dout(dout),
    .o_dout_oe(dout_oe), .o_inout_out(io_out), .o_inout_oe(io_oe), .o_busy(busy));
  sfsp_host host (.i_clock, .i_dout(dout), .i_inout_out(io_out), .i_inout_oe(io_oe),
    .o_pins(pins));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp8
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic wait_idle();
    int k;
    for (k = 0; k < 300 && busy !== 1'b0; k++)
      @(negedge i_clock);
    if (k == 300)
    begin
      n_errors++;
      wrap_up();
    end
  endtask : wait_idle
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na);
    host.start();
    host.xb(op, j);
    for (int i = 2; i > 2 - na; i--)
      host.xb(a[i*8 +: 8], j);
  endtask : cmd
  task automatic one(input logic [7:0] op, input logic [7:0] v, input int nv);
    cmd(op, 24'h0, 0);
    if (nv > 0)
      host.xb(v, s);
    host.stop();
  endtask : one
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_status();
    one(sfsp_pkg::OP_RDSR, 8'h00, 1);
    cmp8("status after reset", 8'h00, s);
    host.mode3 = 1'b1;
    one(sfsp_pkg::OP_WREN, 8'h00, 0);
    one(sfsp_pkg::OP_RDSR, 8'h00, 1);
    cmp8("status in mode 3", 8'h02, s);
    host.mode3 = 1'b0;
    $display("t_status done");
  endtask : t_status
  task automatic t_prog();
    cmd(sfsp_pkg::OP_PROG, 24'h000100, 3);
    host.xb(8'h5a, j);
    host.stop();
    cmp8("busy after program", 8'h01, {7'h0, busy});
    one(sfsp_pkg::OP_RDSR, 8'h00, 1);
    cmp8("busy bit", 8'h01, s & 8'h01);
    wait_idle();
    one(sfsp_pkg::OP_RDSR, 8'h00, 1);
    cmp8("status after program", 8'h00, s);
    cmd(sfsp_pkg::OP_READ, 24'h0000ff, 3);
    host.xb(8'h00, j);
    cmp8("erased byte", 8'hff, j);
    host.xb(8'h00, r1);
    cmp8("inout oe single", 8'h00, {7'h0, io_oe});
    host.stop();
    cmp8("programmed byte", 8'h5a, r1);
    cmd(sfsp_pkg::OP_FREAD, 24'h000100, 3);
    host.xb(8'h00, j);
    host.xb(8'h00, r2);
    host.stop();
    cmp8("fast read", r1, r2);
    cmd(sfsp_pkg::OP_DREAD, 24'h000100, 3);
    host.xb(8'h00, j);
    host.xd(r3);
    cmp8("inout oe dual", 8'h01, {7'h0, io_oe});
    host.stop();
    cmp8("dual read", r1, r3);
    $display("t_prog done");
  endtask : t_prog
  task automatic t_hold();
    one(sfsp_pkg::OP_WREN, 8'h00, 0);
    cmd(sfsp_pkg::OP_RDSR, 24'h0, 0);
    host.pause(1'b1);
    cmp8("oe in pause", 8'h00, {7'h0, dout_oe});
    host.xb(8'hff, j);
    host.pause(1'b0);
    host.xb(8'h00, s);
    host.stop();
    cmp8("status after pause", 8'h02, s);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_guard();
    one(sfsp_pkg::OP_WREN, 8'h00, 0);
    one(sfsp_pkg::OP_WRSR, 8'h80, 1);
    wait_idle();
    host.wg_n = 1'b0;
    one(sfsp_pkg::OP_WREN, 8'h00, 0);
    one(sfsp_pkg::OP_WRSR, 8'h1c, 1);
    cmp8("guarded busy", 8'h00, {7'h0, busy});
    one(sfsp_pkg::OP_RDSR, 8'h00, 1);
    cmp8("guarded status", 8'h80, s & 8'hfc);
    host.wg_n = 1'b1;
    one(sfsp_pkg::OP_WREN, 8'h00, 0);
    one(sfsp_pkg::OP_WRSR, 8'h1c, 1);
    wait_idle();
    one(sfsp_pkg::OP_RDSR, 8'h00, 1);
    cmp8("status written", 8'h1c, s);
    $display("t_guard done");
  endtask : t_guard
  task automatic t_erase();
    logic [7:0] ops [4] = '{sfsp_pkg::OP_SE, sfsp_pkg::OP_BE32, sfsp_pkg::OP_BE64,
      sfsp_pkg::OP_CE};
    foreach (ops[i])
    begin
      one(sfsp_pkg::OP_WREN, 8'h00, 0);
      cmd(ops[i], 24'h7ff000, ops[i] == sfsp_pkg::OP_CE ? 0 : 3);
      host.stop();
      cmp8("erase busy", 8'h01, {7'h0, busy});
      wait_idle();
    end
    $display("t_erase done");
  endtask : t_erase
  initial
  begin
    repeat (6) @(posedge i_clock);
    #1;
    i_rstn = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    t_status();
    one(sfsp_pkg::OP_WREN, 8'h00, 0);
    t_prog();
    t_hold();
    t_guard();
    t_erase();
    wrap_up();
  end
endmodule : sfsp_port_tb

//--- verilog/sfsp_port.sv
// serial flash spi port: slave side, oversampled serial pins, internal array
// Functional notes
// R1: select high deselects; outputs released; busy work keeps going
// R2: select low accepts opcode bytes and drives read data
// R3: after reset, no instruction until select has gone high then low
// R4: outputs change on falling serial clock edge
// R5: guard low with lock bit set blocks status writes
// R6: while paused, outputs float and clock and data are ignored
// R7: leaving pause resumes with all state kept
// R8: array is 32768 pages of 256 bytes, 8 Mbyte
// R9: page program 02h writes up to 256 bytes within one page
// R10: erase 16, 128, 256 pages or whole array; the erase opcodes only clear WEL and set busy, array bytes are left unchanged
// R11: 20h sector erase, d8h 64 KB block erase, 32 KB erase too
// R12: 01h writes the status register
// R13: 03h read, 0bh fast read, 3bh dual read, auto-increment
// R14: serial clock to 80 MHz, dual read two bits per clock; sclk is oversampled on i_clock, so it must stay under 50 MHz at CLK_NS 10
// R15: clock may idle low or high; input sampled on rising edge
// R16: pause starts and ends only while serial clock is low
// R17: inout pin drives only during dual read
// R18: busy bit S0 while working; only status read accepted
// R19: opcode and three address bytes, msb first
module sfsp_port (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  // serial pins
  input  wire sfsp_pkg::sfsp_pins_t i_pins,
  output logic                   o_dout,
  output logic                   o_dout_oe,
  output logic                   o_inout_out,
  output logic                   o_inout_oe,
  // state
  output logic                   o_busy
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  bit [7:0] mem_r [sfsp_pkg::MEM_BYTES];  // bytes kept inverted so a zero start reads erased, see R8

  sfsp_pkg::sfsp_state_t st_r, st_nxt;
  logic                  sclk_d_r, sclk_d_nxt;
  logic                  hold_r, hold_nxt;
  logic                  armed_r, armed_nxt;
  logic [7:0]            sh_r, sh_nxt;
  logic [2:0]            bit_r, bit_nxt;
  logic [1:0]            abyte_r, abyte_nxt;
  logic [7:0]            op_r, op_nxt;
  logic [sfsp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0]            stat_r, stat_nxt;
  logic [7:0]            tx_r, tx_nxt;
  logic                  dout_r, dout_nxt;
  logic                  dio_r, dio_nxt;
  logic                  drv_r, drv_nxt;
  logic [15:0]           busy_cnt_r, busy_cnt_nxt;
  logic                  commit_r, commit_nxt;
  logic [7:0]            wr_byte;
  logic                  wr_en;
  logic                  rise;
  logic                  fall;
  logic                  is_read;

  assign rise = i_pins.sclk & ~sclk_d_r;  // see R15
  assign fall = ~i_pins.sclk & sclk_d_r;  // see R4
  assign is_read = (op_r == sfsp_pkg::OP_READ) || (op_r == sfsp_pkg::OP_FREAD)
                || (op_r == sfsp_pkg::OP_DREAD);
  assign o_busy = stat_r[sfsp_pkg::ST_BUSY];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    sclk_d_nxt = i_pins.sclk;
    hold_nxt = hold_r;
    armed_nxt = armed_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    abyte_nxt = abyte_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    stat_nxt = stat_r;
    tx_nxt = tx_r;
    dout_nxt = dout_r;
    dio_nxt = dio_r;
    drv_nxt = drv_r;
    busy_cnt_nxt = busy_cnt_r;
    commit_nxt = commit_r;
    wr_byte = 8'h00;
    wr_en = 1'b0;
    // background work timer runs regardless of select
    if (busy_cnt_r != 16'h0000)  // see R1
    begin
      busy_cnt_nxt = busy_cnt_r - 16'h0001;
      if (busy_cnt_r == 16'h0001)
        stat_nxt[sfsp_pkg::ST_BUSY] = 1'b0;
    end
    if (!i_pins.sclk)  // see R16
      hold_nxt = !i_pins.hold_n;
    if (i_pins.sel_n)  // see R1
    begin
      armed_nxt = 1'b1;  // see R3
      st_nxt = sfsp_pkg::SFSP_IDLE;
      hold_nxt = 1'b0;
      drv_nxt = 1'b0;
      if (commit_r)  // see R18
      begin
        commit_nxt = 1'b0;
        stat_nxt[sfsp_pkg::ST_WEL] = 1'b0;
        stat_nxt[sfsp_pkg::ST_BUSY] = 1'b1;
        busy_cnt_nxt = 16'(sfsp_pkg::BUSY_CYC);
      end
    end
    else if (!hold_r && armed_r)  // see R6 R7 R3
    begin
      if (st_r == sfsp_pkg::SFSP_IDLE)
      begin
        st_nxt = sfsp_pkg::SFSP_OPC;  // see R2
        bit_nxt = 3'h0;
      end
      else if (rise)
      begin
        sh_nxt = {sh_r[6:0], i_pins.serial_inout};  // see R19
        bit_nxt = bit_r + 3'h1;
        if (bit_r == sfsp_pkg::BIT_LAST)
        begin
          unique case (st_r)
            sfsp_pkg::SFSP_OPC:
            begin
              op_nxt = sh_nxt;
              abyte_nxt = 2'h0;
              st_nxt = sfsp_pkg::SFSP_DONE;
              if (stat_r[sfsp_pkg::ST_BUSY])  // see R18
              begin
                if (sh_nxt == sfsp_pkg::OP_RDSR)
                begin
                  st_nxt = sfsp_pkg::SFSP_DATA;
                  tx_nxt = stat_r;
                end
              end
              else
                unique case (sh_nxt)
                  sfsp_pkg::OP_WREN: stat_nxt[sfsp_pkg::ST_WEL] = 1'b1;
                  sfsp_pkg::OP_WRDI: stat_nxt[sfsp_pkg::ST_WEL] = 1'b0;
                  sfsp_pkg::OP_RDSR:
                  begin
                    st_nxt = sfsp_pkg::SFSP_DATA;
                    tx_nxt = stat_r;
                  end
                  sfsp_pkg::OP_WRSR: st_nxt = sfsp_pkg::SFSP_DATA;  // see R12
                  sfsp_pkg::OP_CE:
                    if (stat_r[sfsp_pkg::ST_WEL])  // see R10
                      commit_nxt = 1'b1;
                  sfsp_pkg::OP_READ, sfsp_pkg::OP_FREAD, sfsp_pkg::OP_DREAD,
                  sfsp_pkg::OP_PROG, sfsp_pkg::OP_SE, sfsp_pkg::OP_BE32,
                  sfsp_pkg::OP_BE64:
                    st_nxt = sfsp_pkg::SFSP_ADDR;  // see R11 R13
                  default: st_nxt = sfsp_pkg::SFSP_DONE;
                endcase
            end
            sfsp_pkg::SFSP_ADDR:
            begin
              addr_nxt = {addr_r[sfsp_pkg::ADDR_W-9:0], sh_nxt};  // see R19
              abyte_nxt = abyte_r + 2'h1;
              if (abyte_r == sfsp_pkg::ADDR_LAST)
              begin
                st_nxt = sfsp_pkg::SFSP_DATA;
                if (op_r == sfsp_pkg::OP_FREAD || op_r == sfsp_pkg::OP_DREAD)
                  st_nxt = sfsp_pkg::SFSP_DUMMY;
                if (is_read)
                  tx_nxt = ~mem_r[addr_nxt];
                if ((op_r == sfsp_pkg::OP_SE || op_r == sfsp_pkg::OP_BE32
                     || op_r == sfsp_pkg::OP_BE64) && stat_r[sfsp_pkg::ST_WEL])
                begin
                  st_nxt = sfsp_pkg::SFSP_DONE;  // see R10 R11
                  commit_nxt = 1'b1;
                end
              end
            end
            sfsp_pkg::SFSP_DUMMY: st_nxt = sfsp_pkg::SFSP_DATA;
            sfsp_pkg::SFSP_DATA:
            begin
              if (op_r == sfsp_pkg::OP_WRSR)
              begin
                st_nxt = sfsp_pkg::SFSP_DONE;
                if (stat_r[sfsp_pkg::ST_WEL]
                    && !(stat_r[sfsp_pkg::ST_LOCK] && !i_pins.wguard_n))  // see R5
                begin
                  stat_nxt = (stat_r & ~sfsp_pkg::ST_WR_MASK)
                           | (sh_nxt & sfsp_pkg::ST_WR_MASK);
                  commit_nxt = 1'b1;
                end
              end
              else if (op_r == sfsp_pkg::OP_PROG && stat_r[sfsp_pkg::ST_WEL])
              begin
                wr_en = 1'b1;  // see R9
                wr_byte = sh_nxt;
                commit_nxt = 1'b1;
                addr_nxt[7:0] = addr_r[7:0] + 8'h01;
              end
            end
            default: st_nxt = st_r;
          endcase
        end
        // dual read takes two bits per clock
        if (st_r == sfsp_pkg::SFSP_DATA && op_r == sfsp_pkg::OP_DREAD)  // see R14
          bit_nxt = bit_r + 3'h2;
      end
      else if (fall && st_r == sfsp_pkg::SFSP_DATA
               && (is_read || op_r == sfsp_pkg::OP_RDSR))  // see R4
      begin
        if (op_r == sfsp_pkg::OP_DREAD)  // see R17
        begin
          drv_nxt = 1'b1;
          dio_nxt = tx_r[7];
          dout_nxt = tx_r[6];
          tx_nxt = {tx_r[5:0], 2'b00};
        end
        else
        begin
          dout_nxt = tx_r[7];
          tx_nxt = {tx_r[6:0], 1'b0};
        end
        if (is_read
            && (bit_r | {2'b00, op_r == sfsp_pkg::OP_DREAD}) == sfsp_pkg::BIT_LAST)  // see R13
        begin
          addr_nxt = addr_r + 1'b1;
          tx_nxt = ~mem_r[addr_r + 1'b1];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      st_r <= sfsp_pkg::SFSP_IDLE;
      sclk_d_r <= 1'b0;
      hold_r <= 1'b0;
      armed_r <= 1'b0;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      abyte_r <= 2'h0;
      op_r <= 8'h00;
      addr_r <= '0;
      stat_r <= sfsp_pkg::ST_RESET;
      tx_r <= 8'h00;
      dout_r <= 1'b0;
      dio_r <= 1'b0;
      drv_r <= 1'b0;
      busy_cnt_r <= 16'h0000;
      commit_r <= 1'b0;
    end
    else if (i_ce)
    begin
      st_r <= st_nxt;
      sclk_d_r <= sclk_d_nxt;
      hold_r <= hold_nxt;
      armed_r <= armed_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      abyte_r <= abyte_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      stat_r <= stat_nxt;
      tx_r <= tx_nxt;
      dout_r <= dout_nxt;
      dio_r <= dio_nxt;
      drv_r <= drv_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      commit_r <= commit_nxt;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_ce && wr_en)
      mem_r[addr_r] <= mem_r[addr_r] | ~wr_byte;  // see R9
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_comb
  begin
    o_dout = dout_r;
    o_inout_out = dio_r;
    o_dout_oe = !i_pins.sel_n && !hold_r && st_r == sfsp_pkg::SFSP_DATA;  // see R1 R6
    o_inout_oe = o_dout_oe && drv_r && op_r == sfsp_pkg::OP_DREAD;        // see R17
  end

endmodule : sfsp_port
